// ---- jtp_pkg.sv ----
package jtp_pkg;
    typedef enum logic [3:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h2,
        ST_CAP_DR   = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR   = 4'h8,
        ST_SEL_IR   = 4'h9,
        ST_CAP_IR   = 4'ha,
        ST_SHIFT_IR = 4'hb,
        ST_EXIT1_IR = 4'hc,
        ST_PAUSE_IR = 4'hd,
        ST_EXIT2_IR = 4'he,
        ST_UPD_IR   = 4'hf
    } jtp_state_e;

    localparam int IR_WIDTH = 3;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_SAMPLE = 3'h4;
    localparam logic [2:0] IR_IDCODE = 3'h6;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPTURE = 3'h4;
    localparam int BSR_LEN = 98;
    localparam int IDR_LEN = 32;
    localparam int RESET_TMS_EDGES = 5;
    // Arbitrary neutral identification value; bit 0 must be 1
    localparam logic [31:0] ID_VALUE = 32'h00012345;
endpackage

// ---- jtp_bsr_latch.sv ----
`timescale 1ns/1ps
module jtp_bsr_latch #(
    parameter int WIDTH = 98
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o
);
    initial begin
        if (WIDTH < 1) begin
            $error("WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            data_o <= '0;
        end else if (load_i) begin
            data_o <= data_i;
        end
    end
endmodule

// ---- jtp_tap.sv ----
`timescale 1ns/1ps
module jtp_tap #(
    parameter int BSR_WIDTH = jtp_pkg::BSR_LEN,
    parameter logic [31:0] ID_CODE = jtp_pkg::ID_VALUE
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [BSR_WIDTH-1:0] pins_i,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    output logic test_mode_o,
    output logic [2:0] instr_o,
    output logic [3:0] state_o,
    output logic [BSR_WIDTH-1:0] bsr_out_o
);
    // Width one is refused so the shift part-select below stays legal
    initial begin
        if (BSR_WIDTH < 2) begin
            $error("BSR_WIDTH must be at least 2");
        end
        if (ID_CODE[0] != 1'b1) begin
            $error("ID_CODE bit 0 must be 1");
        end
    end

    // Pin synchronisers; first stages read only by second stages
    logic tck_m, tck_s, tck_d;
    logic tms_m, tms_s;
    logic tdi_m, tdi_s;
    logic [BSR_WIDTH-1:0] pins_m, pins_s;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            tck_m <= 1'b0;
            tck_s <= 1'b0;
            tck_d <= 1'b0;
            tms_m <= 1'b1;
            tms_s <= 1'b1;
            tdi_m <= 1'b0;
            tdi_s <= 1'b0;
        end else begin
            tck_m <= tck_i;
            tck_s <= tck_m;
            tck_d <= tck_s;
            tms_m <= tms_i;
            tms_s <= tms_m;
            tdi_m <= tdi_i;
            tdi_s <= tdi_m;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pins_m <= '0;
            pins_s <= '0;
        end else begin
            pins_m <= pins_i;
            pins_s <= pins_m;
        end
    end

    logic tck_rise, tck_fall;
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    function automatic jtp_pkg::jtp_state_e step(input jtp_pkg::jtp_state_e s, input logic m);
        case (s)
            jtp_pkg::ST_RESET: step = m ? jtp_pkg::ST_RESET : jtp_pkg::ST_IDLE;
            jtp_pkg::ST_IDLE: step = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
            jtp_pkg::ST_SEL_DR: step = m ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
            jtp_pkg::ST_CAP_DR: step = m ? jtp_pkg::ST_EXIT1_DR : jtp_pkg::ST_SHIFT_DR;
            jtp_pkg::ST_SHIFT_DR: step = m ? jtp_pkg::ST_EXIT1_DR : jtp_pkg::ST_SHIFT_DR;
            jtp_pkg::ST_EXIT1_DR: step = m ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAUSE_DR;
            jtp_pkg::ST_PAUSE_DR: step = m ? jtp_pkg::ST_EXIT2_DR : jtp_pkg::ST_PAUSE_DR;
            jtp_pkg::ST_EXIT2_DR: step = m ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SHIFT_DR;
            jtp_pkg::ST_UPD_DR: step = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
            jtp_pkg::ST_SEL_IR: step = m ? jtp_pkg::ST_RESET : jtp_pkg::ST_CAP_IR;
            jtp_pkg::ST_CAP_IR: step = m ? jtp_pkg::ST_EXIT1_IR : jtp_pkg::ST_SHIFT_IR;
            jtp_pkg::ST_SHIFT_IR: step = m ? jtp_pkg::ST_EXIT1_IR : jtp_pkg::ST_SHIFT_IR;
            jtp_pkg::ST_EXIT1_IR: step = m ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAUSE_IR;
            jtp_pkg::ST_PAUSE_IR: step = m ? jtp_pkg::ST_EXIT2_IR : jtp_pkg::ST_PAUSE_IR;
            jtp_pkg::ST_EXIT2_IR: step = m ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SHIFT_IR;
            jtp_pkg::ST_UPD_IR: step = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
            default: step = jtp_pkg::ST_RESET;
        endcase
    endfunction

    jtp_pkg::jtp_state_e state;

    // Reset is reached within five high edges from any state by the graph itself
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state <= jtp_pkg::ST_RESET;
        end else if (tck_rise) begin
            state <= step(state, tms_s);
        end
    end

    logic [2:0] ir_shift;
    logic [2:0] instr;
    localparam int IDR_W = jtp_pkg::IDR_LEN;
    logic [IDR_W-1:0] id_shift;
    logic bypass_bit;
    logic [BSR_WIDTH-1:0] bsr_shift;

    logic sel_bsr;
    assign sel_bsr = (instr == jtp_pkg::IR_EXTEST) || (instr == jtp_pkg::IR_SAMPLE);

    // Instruction shift path, LSB first
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ir_shift <= jtp_pkg::IR_CAPTURE;
        end else if (tck_rise) begin
            if (state == jtp_pkg::ST_CAP_IR) begin
                ir_shift <= jtp_pkg::IR_CAPTURE;
            end else if (state == jtp_pkg::ST_SHIFT_IR) begin
                ir_shift <= {tdi_s, ir_shift[2:1]};
            end
        end
    end

    // Current instruction changes only in reset or on update-IR falling edge
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            instr <= jtp_pkg::IR_IDCODE;
        end else if (state == jtp_pkg::ST_RESET) begin
            instr <= jtp_pkg::IR_IDCODE;
        end else if (tck_fall && state == jtp_pkg::ST_UPD_IR) begin
            instr <= ir_shift;
        end
    end

    // Data registers; unselected ones hold
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            id_shift <= ID_CODE;
            bypass_bit <= 1'b0;
        end else if (tck_rise) begin
            if (state == jtp_pkg::ST_CAP_DR) begin
                if (instr == jtp_pkg::IR_IDCODE) begin
                    id_shift <= ID_CODE;
                end
                if (instr == jtp_pkg::IR_BYPASS) begin
                    bypass_bit <= 1'b0;
                end
            end else if (state == jtp_pkg::ST_SHIFT_DR) begin
                if (instr == jtp_pkg::IR_IDCODE) begin
                    id_shift <= {tdi_s, id_shift[IDR_W-1:1]};
                end
                if (instr == jtp_pkg::IR_BYPASS) begin
                    bypass_bit <= tdi_s;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            bsr_shift <= '0;
        end else if (tck_rise && sel_bsr) begin
            if (state == jtp_pkg::ST_CAP_DR) begin
                bsr_shift <= pins_s;
            end else if (state == jtp_pkg::ST_SHIFT_DR) begin
                bsr_shift <= {tdi_s, bsr_shift[BSR_WIDTH-1:1]};
            end
        end
    end

    // Holding the latch steady keeps pin outputs quiet while shifting
    logic bsr_load;
    assign bsr_load = tck_fall && state == jtp_pkg::ST_UPD_DR && sel_bsr;

    jtp_bsr_latch #(
        .WIDTH(BSR_WIDTH)
    ) u_latch (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .load_i(bsr_load),
        .data_i(bsr_shift),
        .data_o(bsr_out_o)
    );

    logic dr_bit;
    always_comb begin
        case (instr)
            jtp_pkg::IR_IDCODE: dr_bit = id_shift[0];
            jtp_pkg::IR_BYPASS: dr_bit = bypass_bit;
            jtp_pkg::IR_EXTEST, jtp_pkg::IR_SAMPLE: dr_bit = bsr_shift[0];
            default: dr_bit = bypass_bit;
        endcase
    end

    // Serial output updated on falling edge; tester samples on rising edge
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            tdo_o <= 1'b0;
            tdo_oe_n_o <= 1'b1;
        end else if (tck_fall) begin
            if (state == jtp_pkg::ST_SHIFT_DR) begin
                tdo_o <= dr_bit;
                tdo_oe_n_o <= 1'b0;
            end else if (state == jtp_pkg::ST_SHIFT_IR) begin
                tdo_o <= ir_shift[0];
                tdo_oe_n_o <= 1'b0;
            end else begin
                tdo_oe_n_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            test_mode_o <= 1'b0;
            instr_o <= jtp_pkg::IR_IDCODE;
            state_o <= jtp_pkg::ST_RESET;
        end else begin
            test_mode_o <= (state != jtp_pkg::ST_RESET) && (instr == jtp_pkg::IR_EXTEST);
            instr_o <= instr;
            state_o <= state;
        end
    end

    // Run of high mode-select rises; saturates since any longer run ends the same way
    localparam logic [2:0] HI_SAT = 3'(jtp_pkg::RESET_TMS_EDGES - 1);
    logic [2:0] hi_run;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hi_run <= 3'h0;
        end else if (tck_rise) begin
            if (!tms_s) begin
                hi_run <= 3'h0;
            end else if (hi_run != HI_SAT) begin
                hi_run <= hi_run + 3'h1;
            end
        end
    end

    sequence s_rise_high;
        tck_rise && tms_s;
    endsequence

    sequence s_dr_capture_low;
        state == jtp_pkg::ST_CAP_DR && tck_rise && !tms_s;
    endsequence

    property p_reset_hold;
        @(posedge clk_sys_i) disable iff (reset_i)
        (state == jtp_pkg::ST_RESET && tck_rise && tms_s) |=> state == jtp_pkg::ST_RESET;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("Left reset with TMS high");

    property p_idle_hold;
        @(posedge clk_sys_i) disable iff (reset_i)
        (state == jtp_pkg::ST_IDLE && tck_rise && !tms_s) |=> state == jtp_pkg::ST_IDLE;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("Idle not held");

    property p_sel_ir_reset;
        @(posedge clk_sys_i) disable iff (reset_i)
        (state == jtp_pkg::ST_SEL_IR && tck_rise && tms_s) |=> state == jtp_pkg::ST_RESET;
    endproperty
    a_sel_ir_reset: assert property (p_sel_ir_reset) else $error("Select-IR high missed");

    property p_cap_ir;
        @(posedge clk_sys_i) disable iff (reset_i)
        (state == jtp_pkg::ST_CAP_IR && tck_rise) |=> ir_shift == 3'h4;
    endproperty
    a_cap_ir: assert property (p_cap_ir) else $error("Capture-IR pattern wrong");

    property p_instr_stable;
        @(posedge clk_sys_i) disable iff (reset_i)
        (state != jtp_pkg::ST_UPD_IR && state != jtp_pkg::ST_RESET) |=> $stable(instr);
    endproperty
    a_instr_stable: assert property (p_instr_stable) else $error("Instruction changed");

    property p_upd_ir;
        @(posedge clk_sys_i) disable iff (reset_i)
        (state == jtp_pkg::ST_UPD_IR && tck_fall) |=> instr == $past(ir_shift);
    endproperty
    a_upd_ir: assert property (p_upd_ir) else $error("Update-IR did not latch");

    property p_reset_instr;
        @(posedge clk_sys_i) disable iff (reset_i)
        state == jtp_pkg::ST_RESET |=> instr == 3'h6;
    endproperty
    a_reset_instr: assert property (p_reset_instr) else $error("Reset instr not IDCODE");

    property p_latch_quiet;
        @(posedge clk_sys_i) disable iff (reset_i)
        !bsr_load |=> $stable(bsr_out_o);
    endproperty
    a_latch_quiet: assert property (p_latch_quiet) else $error("Boundary latch moved");

    property p_tdo_off;
        @(posedge clk_sys_i) disable iff (reset_i)
        (tck_fall && state != jtp_pkg::ST_SHIFT_DR && state != jtp_pkg::ST_SHIFT_IR)
            |=> tdo_oe_n_o;
    endproperty
    a_tdo_off: assert property (p_tdo_off) else $error("TDO driven outside shift");

    property p_five_high;
        @(posedge clk_sys_i) disable iff (reset_i)
        (hi_run == HI_SAT) ##0 s_rise_high |=> state == jtp_pkg::ST_RESET;
    endproperty
    a_five_high: assert property (p_five_high) else $error("Reset not reached");

    property p_shift_dr_step;
        @(posedge clk_sys_i) disable iff (reset_i)
        s_dr_capture_low |=> state == jtp_pkg::ST_SHIFT_DR;
    endproperty
    a_shift_dr_step: assert property (p_shift_dr_step) else $error("No shift-DR");

    property p_dr_pause_hold;
        @(posedge clk_sys_i) disable iff (reset_i)
        state == jtp_pkg::ST_PAUSE_DR
            |=> $stable(bsr_shift) && $stable(id_shift) && $stable(bypass_bit);
    endproperty
    a_dr_pause_hold: assert property (p_dr_pause_hold) else $error("Pause-DR moved");

    property p_ir_pause_hold;
        @(posedge clk_sys_i) disable iff (reset_i)
        state == jtp_pkg::ST_PAUSE_IR |=> $stable(ir_shift);
    endproperty
    a_ir_pause_hold: assert property (p_ir_pause_hold) else $error("Pause-IR moved");
endmodule

// ---- jtp_tester.sv ----
`timescale 1ns/1ps
module jtp_tester (
    input wire logic clk_sys_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_n_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o
);
    logic tdo_line;

    // A released line shows the inverse, so a stale bit never passes for data
    assign tdo_line = tdo_oe_n_i ? ~tdo_i : tdo_i;

    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // Test clock stands low between calls; pins move seven system clocks before the rise
    task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
        @(negedge clk_sys_i);
        tms_o = tms_v;
        tdi_o = tdi_v;
        repeat (7) @(negedge clk_sys_i);
        tdo_v = tdo_line;
        tck_o = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        tck_o = 1'b0;
    endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    localparam int BW = 8;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic tck;
    logic tms;
    logic tdi;
    logic [BW-1:0] pins = '0;
    logic tdo;
    logic tdo_oe_n;
    logic test_mode;
    logic [2:0] instr;
    logic [3:0] state;
    logic [BW-1:0] bsr_out;
    logic tdo_s;
    logic [31:0] d;
    int bad_count = 0;
    int tests_run = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    jtp_tap #(.BSR_WIDTH(BW), .ID_CODE(jtp_pkg::ID_VALUE)) u_jtp_tap (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .pins_i(pins), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
        .test_mode_o(test_mode), .instr_o(instr), .state_o(state), .bsr_out_o(bsr_out)
    );

    jtp_tester u_jtp_tester (
        .clk_sys_i(clk_sys_i), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n),
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tstep(input logic tms_v, input logic tdi_v);
        u_jtp_tester.step(tms_v, tdi_v, tdo_s);
    endtask

    // Idle to idle; every scan ends through pause and exit2 to exercise the hold path
    task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic [2:0] prev_instr;
        logic [BW-1:0] prev_bsr;
        prev_instr = instr;
        prev_bsr = bsr_out;
        tstep(1'b1, 1'b0);
        if (is_ir) tstep(1'b1, 1'b0);
        tstep(1'b0, 1'b0);
        check(state, is_ir ? jtp_pkg::ST_CAP_IR : jtp_pkg::ST_CAP_DR);
        tstep(1'b0, 1'b0);
        check(state, is_ir ? jtp_pkg::ST_SHIFT_IR : jtp_pkg::ST_SHIFT_DR);
        // The enable follows the detected fall a few system clocks later
        repeat (4) @(negedge clk_sys_i);
        check(tdo_oe_n, 1'b0);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            tstep(i == n - 1, din[i]);
            dout[i] = tdo_s;
        end
        check(state, is_ir ? jtp_pkg::ST_EXIT1_IR : jtp_pkg::ST_EXIT1_DR);
        tstep(1'b0, 1'b0);
        tstep(1'b0, 1'b0);
        check(state, is_ir ? jtp_pkg::ST_PAUSE_IR : jtp_pkg::ST_PAUSE_DR);
        check(tdo_oe_n, 1'b1);
        check(instr, prev_instr);
        check(bsr_out, prev_bsr);
        tstep(1'b1, 1'b0);
        check(state, is_ir ? jtp_pkg::ST_EXIT2_IR : jtp_pkg::ST_EXIT2_DR);
        tstep(1'b1, 1'b0);
        check(state, is_ir ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_UPD_DR);
        tstep(1'b0, 1'b0);
        check(state, jtp_pkg::ST_IDLE);
    endtask

    task automatic load(input logic [2:0] code);
        logic [31:0] cap;
        scan(1'b1, 3, {29'h0, code}, cap);
        check(cap[2:0], jtp_pkg::IR_CAPTURE);
        check(instr, code);
    endtask

    task automatic t_reset;
        check(state, jtp_pkg::ST_RESET);
        check(instr, jtp_pkg::IR_IDCODE);
        check(test_mode, 1'b0);
        check(tdo_oe_n, 1'b1);
        repeat (3) tstep(1'b1, 1'b0);
        check(state, jtp_pkg::ST_RESET);
        repeat (3) tstep(1'b0, 1'b0);
        check(state, jtp_pkg::ST_IDLE);
    endtask

    task automatic t_idcode;
        scan(1'b0, 32, 32'h0, d);
        check(d, jtp_pkg::ID_VALUE);
    endtask

    task automatic t_codes;
        load(jtp_pkg::IR_SAMPLE);
        check(test_mode, 1'b0);
        pins = 8'ha5;
        scan(1'b0, BW, 32'h3c, d);
        check(d[BW-1:0], 8'ha5);
        check(bsr_out, 8'h3c);
        load(jtp_pkg::IR_EXTEST);
        check(test_mode, 1'b1);
        pins = 8'h5a;
        scan(1'b0, BW, 32'hc3, d);
        check(d[BW-1:0], 8'h5a);
        check(bsr_out, 8'hc3);
        load(jtp_pkg::IR_BYPASS);
        scan(1'b0, 4, 32'hb, d);
        check(d[3:0], 4'h6);
        check(bsr_out, 8'hc3);
        load(jtp_pkg::IR_IDCODE);
        scan(1'b0, 32, 32'h0, d);
        check(d, jtp_pkg::ID_VALUE);
    endtask

    // Four highs from shift-DR stop one short of reset; the fifth lands there
    task automatic t_force_reset;
        load(jtp_pkg::IR_EXTEST);
        tstep(1'b1, 1'b0);
        tstep(1'b0, 1'b0);
        tstep(1'b0, 1'b0);
        check(state, jtp_pkg::ST_SHIFT_DR);
        repeat (4) tstep(1'b1, 1'b0);
        check(state, jtp_pkg::ST_SEL_IR);
        tstep(1'b1, 1'b0);
        check(state, jtp_pkg::ST_RESET);
        tstep(1'b0, 1'b0);
        check(instr, jtp_pkg::IR_IDCODE);
        check(test_mode, 1'b0);
    endtask

    // Mid-run reset from a scan branch; pin syncs restart at the idle pin levels
    task automatic t_async_reset;
        load(jtp_pkg::IR_EXTEST);
        tstep(1'b1, 1'b0);
        check(state, jtp_pkg::ST_SEL_DR);
        @(negedge clk_sys_i);
        reset_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        check(state, jtp_pkg::ST_RESET);
        check(instr, jtp_pkg::IR_IDCODE);
        check(test_mode, 1'b0);
        check(bsr_out, '0);
        repeat (3) tstep(1'b0, 1'b0);
        check(state, jtp_pkg::ST_IDLE);
    endtask

    task automatic results;
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        results();
    end

    initial begin
        repeat (3) @(negedge clk_sys_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        t_reset();
        t_idcode();
        t_codes();
        t_force_reset();
        t_async_reset();
        results();
    end
endmodule
